// file: pkg/pmi_consts.svh
/*
 * constants of the port mac ingress policing control block.
 * assumes inclusion by bare name from the package.
 */
`ifndef PMI_CONSTS_SVH
`define PMI_CONSTS_SVH

// ----------------------------------------------------------------
// register indices and layout
// ----------------------------------------------------------------
`define PMI_IDX_CTRL0      12'h400
`define PMI_IDX_CTRL1      12'h401
`define PMI_IDX_RATE       12'h403
`define PMI_RST_CTRL0      8'h00
`define PMI_RST_CTRL1      8'h00
`define PMI_RST_RATE       8'h00
`define PMI_WMASK_CTRL0    8'h0B
`define PMI_WMASK_CTRL1    8'hBF
`define PMI_WMASK_RATE     8'h7F
`define PMI_C0_JUMBO       0
`define PMI_C0_STORM       1
`define PMI_C1_PASSALL     0
`define PMI_C1_BP          3
`define PMI_RL_PORT        6
`define PMI_RL_PPS         5
`define PMI_RL_FC          4
`define PMI_RL_MODE_HI     3
`define PMI_RL_MODE_LO     2
`define PMI_RL_IFG         1
`define PMI_RL_PRE         0

// ----------------------------------------------------------------
// frame limits, byte weights and bus response codes
// ----------------------------------------------------------------
`define PMI_JUMBO_MAX      14'h2328
`define PMI_STD_MAX        14'h05DC
`define PMI_IFG_BYTES      15'h000C
`define PMI_PRE_BYTES      15'h0008
`define PMI_ONE_PACKET     18'h00001
`define PMI_RESP_OKAY      2'h0
`define PMI_RESP_DECERR    2'h3

`endif

// file: pkg/pmi_pkg.sv
/*
 * types of the port mac ingress policing control block.
 * assumes pmi_consts.svh is on the include path.
 */
package pmi_pkg;
`include "pmi_consts.svh"

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PMI_LIM_ALL      = 2'b00,
		PMI_LIM_BMC_FLD  = 2'b01,
		PMI_LIM_BMC      = 2'b10,
		PMI_LIM_BC       = 2'b11
	} pmi_lim_mode_t;

	typedef enum logic [0:0] {
		PMI_BUS_IDLE     = 1'b0,
		PMI_BUS_RESP     = 1'b1
	} pmi_bus_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic [13:0] payload_len;
		logic [13:0] frame_len;
		logic        crc_err;
		logic        runt;
		logic        bcast;
		logic        mcast;
		logic        flood_uc;
		logic        flow_ctrl;
		logic [1:0]  prio;
	} pmi_frame_t;

	typedef struct packed {
		logic        valid;
		logic        forward;
		logic        mirror_only;
		logic        counted;
		logic        storm_check;
		logic [1:0]  prio;
		logic [17:0] weight;
	} pmi_verdict_t;

	typedef struct packed {
		logic        port;
		logic [3:0]  prio;
	} pmi_over_t;
endpackage : pmi_pkg

// file: rtl/pmi_port_ctrl.sv
/*
 * per-port frame acceptance and ingress policing control with an
 * axi4-lite register slave.
 * assumes frame descriptors, limiter status and duplex/flow control
 * settings come from logic on aclk.
 */
// Local design decision: register access over AXI4-Lite.
// What this block does
// (RULE_01) jumbo bit selects 9000 or 1500 payload
// (RULE_02) storm protection follows control bit one
// (RULE_03) back pressure only in half duplex
// (RULE_04) bad frames dropped, pass-all mirrors them
// (RULE_05) pass-all leaves flow control filtering alone
// (RULE_06) bit six picks port or priority limiting
// (RULE_07) bit five picks packet or bit counting
// (RULE_08) bit four lets overlimit assert flow control
// (RULE_09) also needs port flow control enabled
// (RULE_10) bits three two select counted frames
// (RULE_11) bit one adds twelve gap bytes
// (RULE_12) bit zero adds eight preamble bytes
// (RULE_13) preamble option ignored in packet mode
// (RULE_14) reserved bits keep defaults, ignore writes
module pmi_port_ctrl
	import pmi_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire pmi_frame_t   frame_in,
	input  wire pmi_over_t    over_limit,
	input  wire logic         full_duplex,
	input  wire logic         port_fc_en,
	input  wire logic         fc_frame_pass,
	output pmi_verdict_t      verdict,
	output logic              storm_en,
	output logic              backpressure_en,
	output logic              fc_assert
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic [1:0] reg_sel(input logic [31:0] addr);
		if (addr == {18'h00000, `PMI_IDX_CTRL0, 2'b00})
			return 2'd0;
		else if (addr == {18'h00000, `PMI_IDX_CTRL1, 2'b00})
			return 2'd1;
		else if (addr == {18'h00000, `PMI_IDX_RATE, 2'b00})
			return 2'd2;
		else
			return 2'd3;
	endfunction : reg_sel

	// ----------------------------------------------------------------
	// write channel and registers
	// ----------------------------------------------------------------
	pmi_bus_state_t wr_state_reg, wr_state_next;
	logic        aw_have_reg, aw_have_next;
	logic        w_have_reg, w_have_next;
	logic [31:0] awaddr_reg, awaddr_next;
	logic [7:0]  wdata_reg, wdata_next;
	logic        wstrb_reg, wstrb_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic [7:0]  ctrl0_reg, ctrl0_next;
	logic [7:0]  ctrl1_reg, ctrl1_next;
	logic [7:0]  rate_reg, rate_next;

	assign s_axi_awready = (wr_state_reg == PMI_BUS_IDLE) && !aw_have_reg;
	assign s_axi_wready  = (wr_state_reg == PMI_BUS_IDLE) && !w_have_reg;
	assign s_axi_bvalid  = (wr_state_reg == PMI_BUS_RESP);
	assign s_axi_bresp   = bresp_reg;

	always_comb begin
		wr_state_next = wr_state_reg;
		aw_have_next  = aw_have_reg;
		w_have_next   = w_have_reg;
		awaddr_next   = awaddr_reg;
		wdata_next    = wdata_reg;
		wstrb_next    = wstrb_reg;
		bresp_next    = bresp_reg;
		ctrl0_next    = ctrl0_reg;
		ctrl1_next    = ctrl1_reg;
		rate_next     = rate_reg;
		case (wr_state_reg)
			PMI_BUS_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_next = 1'b1;
					awaddr_next  = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_next = 1'b1;
					wdata_next  = s_axi_wdata[7:0];
					wstrb_next  = s_axi_wstrb[0];
				end
				if (aw_have_reg && w_have_reg) begin
					wr_state_next = PMI_BUS_RESP;
					aw_have_next  = 1'b0;
					w_have_next   = 1'b0;
					bresp_next    = `PMI_RESP_OKAY;
					// writable bits only, reserved read-only bits held
					case (reg_sel(awaddr_reg))
						2'd0: if (wstrb_reg) ctrl0_next =
							wdata_reg & `PMI_WMASK_CTRL0; // RULE_14
						2'd1: if (wstrb_reg) ctrl1_next =
							wdata_reg & `PMI_WMASK_CTRL1; // RULE_14
						2'd2: if (wstrb_reg) rate_next =
							wdata_reg & `PMI_WMASK_RATE; // RULE_14
						default: bresp_next = `PMI_RESP_DECERR;
					endcase
				end
			end
			PMI_BUS_RESP: begin
				if (s_axi_bready)
					wr_state_next = PMI_BUS_IDLE;
			end
			default: wr_state_next = PMI_BUS_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= PMI_BUS_IDLE;
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			awaddr_reg   <= 32'h00000000;
			wdata_reg    <= 8'h00;
			wstrb_reg    <= 1'b0;
			bresp_reg    <= `PMI_RESP_OKAY;
			ctrl0_reg    <= `PMI_RST_CTRL0;
			ctrl1_reg    <= `PMI_RST_CTRL1;
			rate_reg     <= `PMI_RST_RATE;
		end else if (ce) begin
			wr_state_reg <= wr_state_next;
			aw_have_reg  <= aw_have_next;
			w_have_reg   <= w_have_next;
			awaddr_reg   <= awaddr_next;
			wdata_reg    <= wdata_next;
			wstrb_reg    <= wstrb_next;
			bresp_reg    <= bresp_next;
			ctrl0_reg    <= ctrl0_next;
			ctrl1_reg    <= ctrl1_next;
			rate_reg     <= rate_next;
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	pmi_bus_state_t rd_state_reg, rd_state_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;

	assign s_axi_arready = (rd_state_reg == PMI_BUS_IDLE);
	assign s_axi_rvalid  = (rd_state_reg == PMI_BUS_RESP);
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_comb begin
		rd_state_next = rd_state_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		case (rd_state_reg)
			PMI_BUS_IDLE: begin
				if (s_axi_arvalid) begin
					rd_state_next = PMI_BUS_RESP;
					rresp_next    = `PMI_RESP_OKAY;
					case (reg_sel(s_axi_araddr))
						2'd0: rdata_next = {24'h000000, ctrl0_reg};
						2'd1: rdata_next = {24'h000000, ctrl1_reg};
						2'd2: rdata_next = {24'h000000, rate_reg};
						default: begin
							rdata_next = 32'h00000000;
							rresp_next = `PMI_RESP_DECERR;
						end
					endcase
				end
			end
			PMI_BUS_RESP: begin
				if (s_axi_rready)
					rd_state_next = PMI_BUS_IDLE;
			end
			default: rd_state_next = PMI_BUS_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= PMI_BUS_IDLE;
			rdata_reg    <= 32'h00000000;
			rresp_reg    <= `PMI_RESP_OKAY;
		end else if (ce) begin
			rd_state_reg <= rd_state_next;
			rdata_reg    <= rdata_next;
			rresp_reg    <= rresp_next;
		end
	end

	// ----------------------------------------------------------------
	// frame verdict
	// ----------------------------------------------------------------
	pmi_verdict_t verdict_reg, verdict_next;
	logic         storm_reg, storm_next;
	logic         bp_reg, bp_next;
	logic         fc_reg, fc_next;
	logic         pps_mode;
	pmi_lim_mode_t lim_mode;
	logic [13:0]  pay_max;
	logic         bad;
	logic [14:0]  bytes;

	assign pps_mode = rate_reg[`PMI_RL_PPS];
	assign lim_mode = pmi_lim_mode_t'(rate_reg[`PMI_RL_MODE_HI:`PMI_RL_MODE_LO]);
	assign verdict  = verdict_reg;
	assign storm_en = storm_reg;
	assign backpressure_en = bp_reg;
	assign fc_assert = fc_reg;

	always_comb begin
		verdict_next = '0;
		pay_max = ctrl0_reg[`PMI_C0_JUMBO] ? `PMI_JUMBO_MAX
			: `PMI_STD_MAX; // RULE_01
		bad = frame_in.crc_err || frame_in.runt
			|| (frame_in.payload_len > pay_max); // RULE_01
		bytes = {1'b0, frame_in.frame_len};
		if (rate_reg[`PMI_RL_IFG])
			bytes = bytes + `PMI_IFG_BYTES; // RULE_11
		if (rate_reg[`PMI_RL_PRE] && !pps_mode)
			bytes = bytes + `PMI_PRE_BYTES; // RULE_12 RULE_13
		verdict_next.valid = frame_in.valid;
		verdict_next.prio  = frame_in.prio;
		if (frame_in.valid) begin
			if (bad) begin
				// bad frames never forwarded, mirrored only when pass-all is set
				verdict_next.mirror_only = ctrl1_reg[`PMI_C1_PASSALL]; // RULE_04
			end else if (frame_in.flow_ctrl) begin
				verdict_next.forward = fc_frame_pass; // RULE_05
			end else begin
				verdict_next.forward = 1'b1;
			end
			case (lim_mode) // RULE_10
				PMI_LIM_ALL: verdict_next.counted = 1'b1;
				PMI_LIM_BMC_FLD: verdict_next.counted = frame_in.bcast
					|| frame_in.mcast || frame_in.flood_uc;
				PMI_LIM_BMC: verdict_next.counted =
					frame_in.bcast || frame_in.mcast;
				PMI_LIM_BC: verdict_next.counted = frame_in.bcast;
				default: verdict_next.counted = 1'b1;
			endcase
			verdict_next.storm_check = ctrl0_reg[`PMI_C0_STORM]
				&& frame_in.bcast; // RULE_02
		end
		verdict_next.weight = pps_mode ? `PMI_ONE_PACKET
			: {bytes, 3'b000}; // RULE_07
		storm_next = ctrl0_reg[`PMI_C0_STORM]; // RULE_02
		bp_next = ctrl1_reg[`PMI_C1_BP] && !full_duplex; // RULE_03
		fc_next = rate_reg[`PMI_RL_FC] && port_fc_en // RULE_08 RULE_09
			&& (rate_reg[`PMI_RL_PORT] ? over_limit.port
			: |over_limit.prio); // RULE_06
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			verdict_reg <= '0;
			storm_reg   <= 1'b0;
			bp_reg      <= 1'b0;
			fc_reg      <= 1'b0;
		end else if (ce) begin
			verdict_reg <= verdict_next;
			storm_reg   <= storm_next;
			bp_reg      <= bp_next;
			fc_reg      <= fc_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence big_std_frame;
		ce && frame_in.valid && !ctrl0_reg[`PMI_C0_JUMBO]
			&& frame_in.payload_len > `PMI_STD_MAX;
	endsequence

	sequence drop_seen;
		verdict.valid && !verdict.forward;
	endsequence

	jumbo_limit_a: assert property (big_std_frame |=> drop_seen) // RULE_01
		else $error("oversize frame forwarded without jumbo");
	storm_follow_a: assert property (ce ##1 ce |-> // RULE_02
		storm_en == $past(ctrl0_reg[`PMI_C0_STORM]))
		else $error("storm enable not following control");
	bp_half_a: assert property (full_duplex && ce // RULE_03
		|=> !backpressure_en) else $error("back pressure in full duplex");
	passall_a: assert property (ce && frame_in.valid // RULE_04
		&& frame_in.crc_err |=> !verdict.forward && verdict.mirror_only
		== $past(ctrl1_reg[`PMI_C1_PASSALL]))
		else $error("bad frame routed wrongly");
	fcframe_a: assert property (ce && frame_in.valid && !bad // RULE_05
		&& frame_in.flow_ctrl |=> verdict.forward == $past(fc_frame_pass))
		else $error("flow control frame filter wrong");
	port_basis_a: assert property (ce && rate_reg[`PMI_RL_PORT] // RULE_06
		&& !over_limit.port |=> !fc_assert)
		else $error("port based flow control on priority");
	pps_weight_a: assert property (ce && pps_mode // RULE_07 RULE_13
		|=> verdict.weight == `PMI_ONE_PACKET)
		else $error("packet mode weight not one");
	fc_gate_a: assert property (ce // RULE_08 RULE_09
		&& (!rate_reg[`PMI_RL_FC] || !port_fc_en) |=> !fc_assert)
		else $error("flow control without enables");
	bc_only_a: assert property (ce && frame_in.valid // RULE_10
		&& !frame_in.bcast && lim_mode == PMI_LIM_BC |=> !verdict.counted)
		else $error("non broadcast counted");
	rsvd_bits_a: assert property (((ctrl0_reg & ~`PMI_WMASK_CTRL0) // RULE_14
		| (ctrl1_reg & ~`PMI_WMASK_CTRL1) | (rate_reg & ~`PMI_WMASK_RATE))
		== 8'h00) else $error("reserved read-only bit set");
	ifg_weight_a: assert property (ce && frame_in.valid // RULE_11 RULE_12
		&& !pps_mode && rate_reg[`PMI_RL_IFG] && !rate_reg[`PMI_RL_PRE]
		|=> verdict.weight == {$past(frame_in.frame_len) + `PMI_IFG_BYTES,
		3'b000}) else $error("gap bytes not weighted");

endmodule : pmi_port_ctrl

// file: test/pmi_link_model.sv
/*
 * link partner model: presents one frame descriptor per request.
 * assumes the bench raises req just after a rising edge of aclk.
 */
module pmi_link_model
	import pmi_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       req,
	input  wire pmi_frame_t req_frame,
	output pmi_frame_t      frame_in
);
	timeunit 1ns;
	timeprecision 1ps;

	pmi_frame_t nx;

	// idle fields toggle so nothing is read from a stale descriptor
	always_comb begin
		nx = req ? req_frame : ~frame_in;
		nx.valid = req;
	end

	initial frame_in = '0;

	always @(posedge aclk) begin
		frame_in <= nx;
	end
endmodule : pmi_link_model

// file: test/pmi_port_ctrl_tb.sv
/*
 * self-checking bench: axi4-lite register tasks and frame verdicts.
 * assumes pmi_pkg and the link partner model are compiled first.
 */
module pmi_port_ctrl_tb
	import pmi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals and tables
	// ----------------------------------------------------------------
	localparam logic [31:0] ADR [3] = '{32'h00001000, 32'h00001004,
		32'h0000100C};
	localparam logic [7:0]  MSK [3] = '{8'h0B, 8'hBF, 8'h7F};
	localparam logic [7:0]  RLV [5] = '{8'h03, 8'h05, 8'h0A, 8'h2F, 8'h21};
	localparam logic [13:0] PLEN [9] = '{14'h05DC, 14'h05DD, 14'h05DD,
		14'h2328, 14'h2329, 14'h0064, 14'h0064, 14'h0040, 14'h0040};
	localparam logic [5:0]  FLG [9] = '{6'h00, 6'h00, 6'h02, 6'h04,
		6'h06, 6'h22, 6'h10, 6'h0A, 6'h0B};

	logic         aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, req = 1'b0;
	logic         full_duplex = 1'b0, port_fc_en = 1'b0;
	logic         fc_frame_pass = 1'b0;
	logic [31:0]  awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic         arvalid = 1'b0, rready = 1'b0;
	logic         awready, wready, bvalid, arready, rvalid;
	logic [1:0]   bresp, rresp;
	pmi_frame_t   req_frame = '0, frame_in;
	pmi_over_t    over_limit = '0;
	pmi_verdict_t verdict;
	logic         storm_en, backpressure_en, fc_assert;
	int           num_errors = 0, cmp_count = 0;

	pmi_port_ctrl DUT (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.ce              (ce),
		.s_axi_awaddr    (awaddr),
		.s_axi_awvalid   (awvalid),
		.s_axi_awready   (awready),
		.s_axi_wdata     (wdata),
		.s_axi_wstrb     (4'hF),
		.s_axi_wvalid    (wvalid),
		.s_axi_wready    (wready),
		.s_axi_bresp     (bresp),
		.s_axi_bvalid    (bvalid),
		.s_axi_bready    (bready),
		.s_axi_araddr    (araddr),
		.s_axi_arvalid   (arvalid),
		.s_axi_arready   (arready),
		.s_axi_rdata     (rdata),
		.s_axi_rresp     (rresp),
		.s_axi_rvalid    (rvalid),
		.s_axi_rready    (rready),
		.frame_in        (frame_in),
		.over_limit      (over_limit),
		.full_duplex     (full_duplex),
		.port_fc_en      (port_fc_en),
		.fc_frame_pass   (fc_frame_pass),
		.verdict         (verdict),
		.storm_en        (storm_en),
		.backpressure_en (backpressure_en),
		.fc_assert       (fc_assert)
	);

	pmi_link_model link (
		.aclk      (aclk),
		.req       (req),
		.req_frame (req_frame),
		.frame_in  (frame_in)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time,
				what, seen, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, tb, done;
		done = 1'b0;
		r = 2'h2;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 64 && !done; n++) begin
			@(negedge aclk);
			ta = ce & awvalid & awready;
			tw = ce & wvalid & wready;
			tb = ce & bvalid & bready;
			if (tb) r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			done = tb;
		end
		chk(32'(done), 32'h1, "write answer");
	endtask : axi_wr

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic        tk, tr, done;
		logic [31:0] d;
		logic [1:0]  r;
		done = 1'b0;
		d = '0;
		r = '0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 64 && !done; n++) begin
			@(negedge aclk);
			tk = ce & arvalid & arready;
			tr = ce & rvalid & rready;
			d = tr ? rdata : d;
			r = tr ? rresp : r;
			@(posedge aclk);
			if (tk) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			done = tr;
		end
		chk(32'(done), 32'h1, "read answer");
		chk(d, ed, "read data");
		chk(32'(r), 32'(er), "read resp");
	endtask : rd_chk

	task automatic settle();
		repeat (2) @(negedge aclk);
	endtask : settle

	task automatic send(input pmi_frame_t f, output pmi_verdict_t v);
		@(posedge aclk);
		req <= 1'b1;
		req_frame <= f;
		@(posedge aclk);
		req <= 1'b0;
		@(negedge aclk);
		chk(32'(verdict.valid), 32'h0, "early verdict");
		@(negedge aclk);
		v = verdict;
	endtask : send

	function automatic pmi_verdict_t exp_v(input pmi_frame_t f,
		input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] rl);
		pmi_verdict_t e;
		logic         bad;
		logic [17:0]  bytes;
		bad = f.crc_err | f.runt
			| (f.payload_len > (c0[0] ? 14'h2328 : 14'h05DC));
		e = '0;
		e.valid = 1'b1;
		e.forward = bad ? 1'b0 : (f.flow_ctrl ? fc_frame_pass : 1'b1);
		e.mirror_only = bad & c1[0];
		case (rl[3:2])
			2'h0: e.counted = 1'b1;
			2'h1: e.counted = f.bcast | f.mcast | f.flood_uc;
			2'h2: e.counted = f.bcast | f.mcast;
			default: e.counted = f.bcast;
		endcase
		e.storm_check = f.bcast & c0[1];
		e.prio = f.prio;
		bytes = 18'(f.frame_len) + (rl[1] ? 18'h0000C : 18'h00000)
			+ (rl[0] ? 18'h00008 : 18'h00000);
		e.weight = rl[5] ? 18'h00001 : (bytes << 3);
		return e;
	endfunction : exp_v

	// ----------------------------------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		forever #20 aclk = ~aclk;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		give_verdict();
	end

	initial begin : main
		pmi_frame_t   f;
		pmi_verdict_t v;
		pmi_verdict_t e;
		logic [1:0]   r;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd_chk(ADR[i], 32'h0, 2'h0);
			wr(ADR[i], 32'hFFFFFFFF);
			rd_chk(ADR[i], {24'h0, MSK[i]}, 2'h0);
			wr(ADR[i], 32'h0);
		end
		axi_wr(32'h00001008, 32'h000000FF, r);
		chk(32'(r), 32'h3, "unmapped write");
		rd_chk(32'h00001008, 32'h0, 2'h3);
		rd_chk(ADR[0], 32'h0, 2'h0);
		for (int i = 0; i < 4; i++) begin
			wr(ADR[0], {30'h0, i[0], 1'b0});
			wr(ADR[1], {28'h0, i[1], 3'h0});
			@(posedge aclk);
			full_duplex <= i[0];
			settle();
			chk(32'(storm_en), 32'(i[0]), "storm");
			chk(32'(backpressure_en), 32'(i[1] & !i[0]), "bp");
		end
		@(posedge aclk);
		ce <= 1'b0;
		full_duplex <= 1'b0;
		settle();
		chk(32'(backpressure_en), 32'h0, "bp frozen");
		@(posedge aclk);
		ce <= 1'b1;
		settle();
		chk(32'(backpressure_en), 32'h1, "bp resumed");
		for (int i = 0; i < 16; i++) begin
			wr(ADR[2], {25'h0, i[2], 1'b0, i[0], 4'h0});
			@(posedge aclk);
			port_fc_en <= i[1];
			over_limit <= i[3] ? 5'h10 : 5'h04;
			settle();
			e.valid = i[0] & i[1] & (i[2] == i[3]);
			chk(32'(fc_assert), 32'(e.valid), "fc");
		end
		wr(ADR[0], 32'h02);
		for (int k = 0; k < 20; k++) begin
			if (k % 4 == 0) begin
				wr(ADR[2], {24'h0, RLV[k / 4]});
			end
			f = '0;
			f.frame_len = 14'h0040 + 14'(k);
			f.payload_len = 14'h002E;
			f.prio = 2'(k);
			f.bcast = (k % 4 == 0);
			f.mcast = (k % 4 == 1);
			f.flood_uc = (k % 4 == 2);
			send(f, v);
			e = exp_v(f, 8'h02, 8'h00, RLV[k / 4]);
			chk(32'(v.weight), 32'(e.weight), "weight");
			chk(32'(v), 32'(e), "verdict");
		end
		for (int j = 0; j < 9; j++) begin
			wr(ADR[0], {31'h0, FLG[j][2]});
			wr(ADR[1], {31'h0, FLG[j][1]});
			@(posedge aclk);
			fc_frame_pass <= FLG[j][0];
			f = '0;
			f.payload_len = PLEN[j];
			f.frame_len = PLEN[j] + 14'h0012;
			f.crc_err = FLG[j][5];
			f.runt = FLG[j][4];
			f.flow_ctrl = FLG[j][3];
			send(f, v);
			e = exp_v(f, {7'h0, FLG[j][2]}, {7'h0, FLG[j][1]}, 8'h00);
			chk(32'(v.forward), 32'(e.forward), "fwd");
			chk(32'(v.mirror_only), 32'(e.mirror_only), "mirror");
		end
		give_verdict();
	end
endmodule : pmi_port_ctrl_tb
